/* File: design/swfb_regs.vh */
`ifndef SWFB_REGS_VH
`define SWFB_REGS_VH
// quarter-cycle phase codes
`define SWFB_Q1            2'b00
`define SWFB_Q2            2'b01
`define SWFB_Q3            2'b10
`define SWFB_Q4            2'b11
// indexed literal offset window upper bound (95)
`define SWFB_ILO_MAX       8'h5F
// access bank split: lower part of bank 0, upper part in bank 15
`define SWFB_ACC_HI_BANK   4'hF
`define SWFB_ACC_LO_BANK   4'h0
// field positions of the 16-bit instruction word
`define SWFB_OPC_HI        15
`define SWFB_OPC_LO        10
`define SWFB_D_BIT         9
`define SWFB_A_BIT         8
`define SWFB_F_HI          7
`define SWFB_F_LO          0
`define SWFB_OPC           6'h16
// reset values
`define SWFB_W_RST         8'h00
`define SWFB_C_RST         1'b0
`define SWFB_IR_RST        16'h0000
`define SWFB_ADDR_RST      12'h000
`define SWFB_RES_RST       8'h00
`endif

/* File: design/swfb_file_mem.v */
`timescale 1ns/1ps
// general purpose register file, 4096 x 8, registered read data
module swfb_file_mem (
  input  wire        i_clk,
  input  wire [11:0] i_raddr,
  output reg  [7:0]  o_rdata,
  input  wire        i_we,
  input  wire [11:0] i_waddr,
  input  wire [7:0]  i_wdata
);
  reg [7:0] mem_r [0:4095];

  // one write port and one registered read port
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule

/* File: design/swfb_exec.v */
`timescale 1ns/1ps
`include "swfb_regs.vh"
module swfb_exec (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_valid,
  input  wire [15:0] i_instr,
  input  wire [3:0]  i_bank_select_register,
  input  wire [11:0] i_index_base,
  input  wire        i_ext_en,
  output reg         o_ready,
  output reg         o_done,
  output reg  [7:0]  o_work,
  output reg         o_carry,
  output reg  [7:0]  o_result,
  output reg  [11:0] o_addr
);
  ////////////////////////////////////////////////////////////////////////
  // sequencer states: idle between cycles, run for the four quarters
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        state_r;
  reg        state_nxt;
  reg [1:0]  q_r;
  reg [15:0] ir_r;
  reg [11:0] addr_r;
  reg [7:0]  diff_r;
  reg        carry_nxt_r;
  reg        wr_en;
  wire [7:0] file_data;
  wire       run_w;
  wire       q1_w;
  wire       q3_w;
  wire       q4_w;
  wire       op_w;
  wire       dest_file_w;
  wire       access_w;
  wire [7:0] f_w;

  ////////////////////////////////////////////////////////////////////////
  // address resolution: access bank, banked, or indexed literal offset
  // the indexed sum wraps at twelve bits, so a base near the top of data
  // memory folds back to bank 0; callers must keep base plus offset in range
  // the access bank is split: low half of f in bank 0, high half in bank 15
  // bank and base are read live, so they must not move before the q1 edge
  function [11:0] swfb_resolve;
    input [7:0]  f;
    input        a;
    input        ext;
    input [3:0]  bank;
    input [11:0] base;
    begin
      if (a) begin
        swfb_resolve = {bank, f};
      end else if (ext && (f <= `SWFB_ILO_MAX)) begin
        swfb_resolve = base + {4'h0, f};
      end else if (f[7]) begin
        swfb_resolve = {`SWFB_ACC_HI_BANK, f};
      end else begin
        swfb_resolve = {`SWFB_ACC_LO_BANK, f};
      end
    end
  endfunction

  // subtract with borrow; returns {carry, result}, carry set means no borrow
  // adding the inverse of w plus the carry equals subtracting w and the
  // borrow, and leaves the carry out in the ninth bit with no extra logic
  function [8:0] swfb_sub;
    input [7:0] f;
    input [7:0] w;
    input       c;
    reg   [8:0] t;
    begin
      t = {1'b0, f} + {1'b0, ~w} + {8'h00, c};
      swfb_sub = t;
    end
  endfunction

  // opcode match; a foreign word still burns one cycle but changes nothing
  function swfb_is_op;
    input [15:0] word;
    begin
      swfb_is_op = (word[`SWFB_OPC_HI:`SWFB_OPC_LO] == `SWFB_OPC);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // quarter and operand decode, shared by the sequencer and the strobes;
  // all of it comes from registers, so the strobes are glitch free per edge
  assign run_w       = (state_r == ST_RUN);
  assign q1_w        = run_w && (q_r == `SWFB_Q1);
  assign q3_w        = run_w && (q_r == `SWFB_Q3);
  assign q4_w        = run_w && (q_r == `SWFB_Q4);
  assign op_w        = swfb_is_op(ir_r);
  assign dest_file_w = ir_r[`SWFB_D_BIT];
  assign access_w    = ir_r[`SWFB_A_BIT];
  assign f_w         = ir_r[`SWFB_F_HI:`SWFB_F_LO];

  ////////////////////////////////////////////////////////////////////////
  // read and write share one address: the operand is read in q2 and the
  // result goes back in q4 of the same cycle, so no forwarding is needed
  // between two words, since the next read comes a full cycle later
  swfb_file_mem swfb_file_mem_inst (
    .i_clk   (i_clk),
    .i_raddr (addr_r),
    .o_rdata (file_data),
    .i_we    (wr_en),
    .i_waddr (addr_r),
    .i_wdata (diff_r)
  );

  // take a new instruction only between cycles
  // ready drops for exactly the four quarters; a word offered meanwhile
  // is simply not taken and must be held until ready returns
  always @* begin
    state_nxt = state_r;
    o_ready   = (state_r == ST_IDLE);
    case (state_r)
      ST_IDLE: begin
        if (i_valid) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (q4_w) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // write only for our opcode with destination bit set
  always @* begin
    wr_en = q4_w && op_w && dest_file_w;
  end

  ////////////////////////////////////////////////////////////////////////
  // state and quarter counter; the counter wraps from q4 back to q1 by itself
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      q_r     <= `SWFB_Q1;
    end else begin
      state_r <= state_nxt;
      if (run_w) begin
        q_r <= q_r + 2'b01;
      end else begin
        q_r <= `SWFB_Q1;
      end
    end
  end

  // instruction register, loaded only at the take edge
  always @(posedge i_clk) begin
    if (i_rst) begin
      ir_r <= `SWFB_IR_RST;
    end else if (o_ready && i_valid) begin
      ir_r <= i_instr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // q1 decode: resolve the operand address; bank and base are sampled here,
  // so the core must hold them steady from the take edge to this one
  always @(posedge i_clk) begin
    if (i_rst) begin
      addr_r <= `SWFB_ADDR_RST;
    end else if (q1_w) begin
      addr_r <= swfb_resolve(f_w, access_w, i_ext_en,
                             i_bank_select_register, i_index_base);
    end
  end

  // q2 read happens inside the memory: its read port registers the operand
  // on the q2 edge, so file_data is settled for the whole q3 quarter

  // q3 process: the borrow comes from the carry as it stood before this cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      diff_r      <= `SWFB_RES_RST;
      carry_nxt_r <= `SWFB_C_RST;
    end else if (q3_w) begin
      {carry_nxt_r, diff_r} <= swfb_sub(file_data, o_work, o_carry);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // q4 write: file destination goes through wr_en, work destination here;
  // a foreign opcode leaves every architectural output untouched
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_work   <= `SWFB_W_RST;
      o_carry  <= `SWFB_C_RST;
      o_result <= `SWFB_RES_RST;
      o_addr   <= `SWFB_ADDR_RST;
    end else if (q4_w && op_w) begin
      if (!dest_file_w) begin
        o_work <= diff_r;
      end
      o_carry  <= carry_nxt_r;
      o_result <= diff_r;
      o_addr   <= addr_r;
    end
  end

  // end-of-cycle pulse, one clock wide, for every word taken
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= q4_w;
    end
  end
endmodule

/* File: tb/swfb_exec_properties.sv */
`timescale 1ns/1ps
module swfb_exec_properties (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_valid,
  input wire [15:0] i_instr,
  input wire [3:0]  i_bank_select_register,
  input wire [11:0] i_index_base,
  input wire        i_ext_en,
  input wire        o_ready,
  input wire        o_done,
  input wire [7:0]  o_work,
  input wire [7:0]  o_result,
  input wire [11:0] o_addr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reg [15:0] ir_r;
  reg [3:0]  bk_r;
  reg [11:0] bs_r;
  reg        ex_r;
  reg [7:0]  wq_r;
  wire       op = ir_r[15:10] == 6'h16;
  wire       ilo = ex_r && ir_r[7:0] <= 8'h5F;
  // operands at the take edge, since the bench may change them mid-cycle
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      ir_r <= i_instr;
      bk_r <= i_bank_select_register;
      bs_r <= i_index_base;
      ex_r <= i_ext_en;
      wq_r <= o_work;
    end
  end
  sequence s_take; i_valid && o_ready; endsequence
  sequence s_quarters; !o_ready [*4] ##1 o_ready; endsequence
  a_done_latency: assert property (s_take |-> ##5 o_done)
    else $error("done not five cycles after take");
  a_quarter_busy: assert property (s_take |=> s_quarters)
    else $error("busy window not four quarters");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_bank_select: assert property (o_done && op && ir_r[8]
    |-> o_addr == {bk_r, ir_r[7:0]})
    else $error("bank select address wrong");
  a_access_bank: assert property (o_done && op && !ir_r[8] && !ilo
    |-> o_addr == {{4{ir_r[7]}}, ir_r[7:0]})
    else $error("access bank address wrong");
  a_indexed_addr: assert property (o_done && op && !ir_r[8] && ilo
    |-> o_addr == bs_r + ir_r[7:0])
    else $error("indexed address wrong");
  a_dest_file: assert property (o_done && op && ir_r[9] |-> o_work == wq_r)
    else $error("work changed on file destination");
  a_result_holds: assert property (!o_done |-> $stable(o_result) && $stable(o_addr))
    else $error("result moved outside the write quarter");
endmodule
bind swfb_exec swfb_exec_properties swfb_exec_properties_inst (
  .i_clk                  (i_clk),
  .i_rst                  (i_rst),
  .i_valid                (i_valid),
  .i_instr                (i_instr),
  .i_bank_select_register (i_bank_select_register),
  .i_index_base           (i_index_base),
  .i_ext_en               (i_ext_en),
  .o_ready                (o_ready),
  .o_done                 (o_done),
  .o_work                 (o_work),
  .o_result               (o_result),
  .o_addr                 (o_addr)
);

/* File: tb/swfb_exec_tb.sv */
`timescale 1ns/1ps
module swfb_exec_tb;
  reg i_clk = 0, i_rst = 1, i_valid = 0, i_ext_en = 0, c = 0, k;
  reg [15:0] i_instr = 0;
  reg [3:0]  i_bank_select_register = 0;
  reg [11:0] i_index_base = 0, ad;
  reg [7:0]  w = 0, m, r;
  wire       o_ready, o_done, o_carry;
  wire [7:0] o_work, o_result;
  wire [11:0] o_addr;
  integer seed = 32'hc5a4, error_cnt = 0, total_checks = 0, cyc = 0, i, n;
  swfb_exec swfb_exec_inst (
    .i_clk                  (i_clk),
    .i_rst                  (i_rst),
    .i_valid                (i_valid),
    .i_instr                (i_instr),
    .i_bank_select_register (i_bank_select_register),
    .i_index_base           (i_index_base),
    .i_ext_en               (i_ext_en),
    .o_ready                (o_ready),
    .o_done                 (o_done),
    .o_work                 (o_work),
    .o_carry                (o_carry),
    .o_result               (o_result),
    .o_addr                 (o_addr)
  );
  initial forever #4 i_clk = ~i_clk;
  task chk(input [11:0] got, input [11:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // expected result: f minus w minus borrow, carry high when nothing borrowed
  function [8:0] exp_sub(input [7:0] f, input [7:0] wv, input cv);
    reg [8:0] t;
    begin
      t = {1'b0, f} - {1'b0, wv} - {8'h00, ~cv};
      exp_sub = {~t[8], t[7:0]};
    end
  endfunction
  // expected operand address from the access bit, bank, base and extension
  function [11:0] exp_addr(input [15:0] ins, input [3:0] bk, input [11:0] bs, input ex);
    begin
      if (ins[8]) exp_addr = {bk, ins[7:0]};
      else if (ex && ins[7:0] <= 8'h5F) exp_addr = bs + {4'h0, ins[7:0]};
      else exp_addr = {{4{ins[7]}}, ins[7:0]};
    end
  endfunction
  task close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard: the run needs about 300 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_rst = 0;
    for (i = 0; i < 60; i = i + 1) begin
      // first items pin the indexed boundary, the third a foreign opcode
      i_instr = $random(seed);
      i_instr[15:10] = 6'h16;
      i_bank_select_register = $random(seed);
      i_index_base = $random(seed);
      i_ext_en = (i < 2) | $random(seed);
      if (i < 2) i_instr[8:0] = 9'h05F + i[8:0];
      if (i == 2) i_instr[15:10] = 6'h00;
      ad = exp_addr(i_instr, i_bank_select_register, i_index_base, i_ext_en);
      m = $random(seed);
      swfb_exec_inst.swfb_file_mem_inst.mem_r[ad] = m; // memory has no load port
      i_valid = 1;
      @(posedge i_clk);
      #1 i_valid = 0;
      n = 0;
      while (!o_done && n < 8) begin
        @(posedge i_clk);
        #1 n = n + 1;
      end
      // done is launched on the q4 edge, four edges after the take edge
      chk(n, 4);
      if (i != 2) begin
        {k, r} = exp_sub(m, w, c);
        c = k;
        if (!i_instr[9]) w = r;
        chk(o_addr, ad);
        chk(o_result, r);
        chk(o_carry, c);
        if (i_instr[9]) chk(swfb_exec_inst.swfb_file_mem_inst.mem_r[ad], r);
      end else begin
        chk(swfb_exec_inst.swfb_file_mem_inst.mem_r[ad], m);
      end
      chk(o_work, w);
    end
    close_out;
  end
endmodule
